/* File: hdl/lhp_pkg.sv */
// constants for the lcd host port with display-ram access
// assumes one system clock plus a host serial clock; no other bus
package lhp_pkg;
    localparam int DATA_W = 8;
    localparam int ROW_BITS = 208;
    localparam int LINES = 69;
    localparam int PIX = 104;
    localparam int NIB_W = 4;
    // pixel code width and byte-slot shift inside a ram row
    localparam int CODE_W = 2;
    localparam int BYTE_SH = 3;

    localparam logic [4:0] COL_MAX = 5'h19;
    localparam logic [6:0] LINE_MAX = 7'h44;

    // register addresses (high nibble of a register write) and bank numbers
    localparam logic [3:0] BANK_REG_ADDR = 4'hF;
    localparam logic [3:0] RA_BANK = 4'h2;
    localparam logic [3:0] RA_ADDR = 4'h0;
    localparam logic [3:0] B0_COL_LO = 4'h0;
    localparam logic [3:0] B0_COL_HI = 4'h1;
    localparam logic [3:0] B0_LINE_LO = 4'h2;
    localparam logic [3:0] B0_LINE_HI = 4'h3;
    localparam logic [3:0] B0_ADDR_CTL = 4'h4;
    localparam logic [3:0] B0_START_LO = 4'h5;
    localparam logic [3:0] B0_START_HI = 4'h6;
    localparam logic [3:0] B0_MODE = 4'h7;
    localparam logic [3:0] PAL_BANK = 4'h1;

    // field positions
    localparam int CTL_XINC = 0;
    localparam int CTL_YINC = 1;
    localparam int CTL_REF = 2;
    localparam int MODE_INV = 0;
    localparam int MODE_MONO = 1;
    localparam int MODE_PWM = 2;

    // reset values
    localparam logic [3:0] PAL0_RST = 4'h0;
    localparam logic [3:0] PAL1_RST = 4'h5;
    localparam logic [3:0] PAL2_RST = 4'hA;
    localparam logic [3:0] PAL3_RST = 4'hF;

    // modulation period per frame sequence
    localparam logic [3:0] GRAY_VAR_STEPS = 4'hF;
    localparam logic [3:0] GRAY_FIX_STEPS = 4'h3;

    localparam logic [2:0] SER_LAST = 3'h7;

    // synchroniser lane positions
    localparam int SI_CS = 0;
    localparam int SI_RS = 1;
    localparam int SI_RDB = 2;
    localparam int SI_WRB = 3;
    localparam int SI_STYLE = 4;
    localparam int SI_PS = 5;
    localparam int SI_TOG = 6;
    localparam int SI_LP = 7;
    localparam int SI_FM = 8;
    localparam int SI_DATA = 9;
    localparam int SYN_W = SI_DATA + DATA_W;
endpackage : lhp_pkg

/* File: hdl/lhp_top.sv */
// host port, register file, display ram and line readout of a 4-gray lcd driver
// assumes host pins and display timing pulses are asynchronous to ref_clk_i;
// serial_clk_i is the host serial clock and may stop outside a byte
//
// Behaviour
// - parallel 8-bit bus or serial path by pin
// - style pin: 68 strobes high, 80 strobes low
// - select high register, low display ram
// - serial shifter cleared while chip select high
// - msb first, byte formed at eighth clock
// - serial byte goes to ram or register
// - serial transfers only whole bytes
// - serial path never reads back
// - write on write-strobe rise or enable fall
// - first ram read after change is dummy
// - register read returns address on low nibble
// - bank register at 0FH in every bank
// - line counter preset on frame, counts lines
// - ram 208 by 69, columns 00H-19H
// - column/line auto-increment after ram access
// - line latched on pulse rise, shown on fall
// - invert bit flips mono dot polarity
// - reversed segments use 19H minus column
// - 2-bit pixels through palette or fixed levels
// - palettes reset to 0, 5, A, F
module lhp_top (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic par_ser_sel_i,
    input wire logic bus_style_pin_i,
    input wire logic chip_sel_n_i,
    input wire logic ram_or_reg_sel_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic [lhp_pkg::DATA_W-1:0] host_data_bus_i,
    input wire logic line_pulse_i,
    input wire logic frame_marker_i,
    output logic [lhp_pkg::DATA_W-1:0] host_data_bus_o,
    output logic host_data_bus_oe_o,
    output logic [lhp_pkg::ROW_BITS-1:0] seg_on_o
);
    import lhp_pkg::*;

    typedef struct packed {
        logic [2:0] cnt;
        logic [6:0] sh;
    } lhp_shift_t;

    typedef struct packed {
        logic tog;
        logic rs;
        logic [DATA_W-1:0] data;
    } lhp_hold_t;

    typedef struct packed {
        logic [SYN_W-1:0] meta;
        logic [SYN_W-1:0] stab;
        logic rd_q;
        logic wr_q;
        logic tog_q;
        logic lp_q;
        logic fm_q;
        logic rd_rs;
        logic [3:0] bank;
        logic [3:0] rptr;
        logic [4:0] x;
        logic [6:0] y;
        logic xinc;
        logic yinc;
        logic rev_seg;
        logic [6:0] start;
        logic inv;
        logic mono;
        logic pwm;
        logic [3:0][3:0] pal;
        logic [DATA_W-1:0] rbuf;
        logic [6:0] line_cnt;
        logic [ROW_BITS-1:0] latch;
        logic [3:0] phase;
        logic [ROW_BITS-1:0] seg;
        logic [DATA_W-1:0] dout;
        logic doe;
    } lhp_state_t;

    localparam lhp_state_t ST_RST = '{
        pal: {PAL3_RST, PAL2_RST, PAL1_RST, PAL0_RST},
        default: '0
    };

    lhp_state_t q_ff;
    lhp_state_t nxt_q;
    lhp_shift_t sh_ff;
    lhp_shift_t nxt_sh;
    lhp_hold_t hold_ff;
    lhp_hold_t nxt_hold;

    logic [ROW_BITS-1:0] ram [LINES];
    logic mem_we;
    logic [6:0] mem_row;
    logic [4:0] mem_col;
    logic [DATA_W-1:0] mem_byte;
    logic ser_clr_b;
    logic [4:0] eff_col;
    logic wr_fire;
    logic wr_rs;
    logic [DATA_W-1:0] wr_data;
    logic rd_start;
    logic rd_end;
    logic lp_rise;
    logic lp_fall;
    logic fm_rise;

    // ---------------- serial link domain ----------------
    // select high holds the shifter cleared, so a torn byte never lands
    assign ser_clr_b = rst_b_i & ~chip_sel_n_i;

    always_comb begin
        nxt_sh.sh = {sh_ff.sh[5:0], serial_data_i};
        nxt_sh.cnt = 3'(sh_ff.cnt + 3'h1);
        nxt_hold = hold_ff;
        if (sh_ff.cnt == SER_LAST) begin
            nxt_hold.tog = ~hold_ff.tog;
            nxt_hold.data = {sh_ff.sh, serial_data_i};
            nxt_hold.rs = ram_or_reg_sel_i;
        end
    end

    always_ff @(posedge serial_clk_i or negedge ser_clr_b) begin
        if (!ser_clr_b) begin
            sh_ff <= '0;
        end else begin
            sh_ff <= nxt_sh;
        end
    end

    // held byte stays put for eight serial clocks, far longer than the toggle sync
    always_ff @(posedge serial_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hold_ff <= '0;
        end else begin
            hold_ff <= nxt_hold;
        end
    end

    // ---------------- system clock domain ----------------
    function automatic logic [4:0] col_map(input logic invert_bit, input logic [4:0] x);
        col_map = invert_bit ? 5'(COL_MAX - x) : x;
    endfunction : col_map

    function automatic logic [3:0] reg_val(input lhp_state_t s, input logic [3:0] a);
        reg_val = '0;
        if (a == BANK_REG_ADDR) begin
            reg_val = s.bank;
        end else if (s.bank == PAL_BANK && a < NIB_W) begin
            reg_val = s.pal[a[1:0]];
        end else if (s.bank == RA_BANK && a == RA_ADDR) begin
            reg_val = s.rptr;
        end else if (s.bank == '0) begin
            unique case (a)
                B0_COL_LO: reg_val = s.x[3:0];
                B0_COL_HI: reg_val = {3'h0, s.x[4]};
                B0_LINE_LO: reg_val = s.y[3:0];
                B0_LINE_HI: reg_val = {1'b0, s.y[6:4]};
                B0_ADDR_CTL: reg_val = {1'b0, s.rev_seg, s.yinc, s.xinc};
                B0_START_LO: reg_val = s.start[3:0];
                B0_START_HI: reg_val = {1'b0, s.start[6:4]};
                B0_MODE: reg_val = {1'b0, s.pwm, s.mono, s.inv};
                default: reg_val = '0;
            endcase
        end
    endfunction : reg_val

    always_comb begin
        logic [SYN_W-1:0] s;
        logic par;
        logic rd_act;
        logic wr_act;
        logic ram_acc;
        logic [3:0] wa;
        logic [3:0] wv;
        logic [6:0] base;
        logic [3:0] steps;
        logic [1:0] code;
        logic [3:0] level;
        s = q_ff.stab;
        par = 1'b0;
        rd_act = 1'b0;
        wr_act = 1'b0;
        ram_acc = 1'b0;
        wa = '0;
        wv = '0;
        base = '0;
        steps = '0;
        code = '0;
        level = '0;
        nxt_q = q_ff;
        mem_we = 1'b0;
        mem_row = q_ff.y;
        mem_col = '0;
        mem_byte = '0;

        nxt_q.meta = {host_data_bus_i, frame_marker_i, line_pulse_i, hold_ff.tog,
                      par_ser_sel_i, bus_style_pin_i, write_strobe_n_i,
                      read_strobe_n_i, ram_or_reg_sel_i, chip_sel_n_i};
        nxt_q.stab = q_ff.meta;

        par = s[SI_PS];
        // 68 style: read-strobe pin is enable, write-strobe pin is direction
        if (s[SI_STYLE]) begin
            rd_act = par & ~s[SI_CS] & s[SI_RDB] & s[SI_WRB];
            wr_act = par & ~s[SI_CS] & s[SI_RDB] & ~s[SI_WRB];
        end else begin
            rd_act = par & ~s[SI_CS] & ~s[SI_RDB];
            wr_act = par & ~s[SI_CS] & ~s[SI_WRB];
        end
        nxt_q.rd_q = rd_act;
        nxt_q.wr_q = wr_act;
        rd_start = rd_act & ~q_ff.rd_q;
        rd_end = ~rd_act & q_ff.rd_q;
        nxt_q.tog_q = s[SI_TOG];

        // write commits at the trailing edge of the write phase
        wr_fire = (~wr_act & q_ff.wr_q) | (~par & (s[SI_TOG] != q_ff.tog_q));
        wr_rs = par ? s[SI_RS] : hold_ff.rs;
        wr_data = par ? s[SI_DATA +: DATA_W] : hold_ff.data;
        wa = wr_data[7:4];
        wv = wr_data[3:0];
        eff_col = col_map(q_ff.rev_seg, q_ff.x);

        if (wr_fire && wr_rs) begin
            if (wa == BANK_REG_ADDR) begin
                nxt_q.bank = wv;
            end else if (q_ff.bank == PAL_BANK && wa < NIB_W) begin
                nxt_q.pal[wa[1:0]] = wv;
            end else if (q_ff.bank == RA_BANK && wa == RA_ADDR) begin
                nxt_q.rptr = wv;
            end else if (q_ff.bank == '0) begin
                unique case (wa)
                    B0_COL_LO: nxt_q.x[3:0] = wv;
                    B0_COL_HI: nxt_q.x[4] = wv[0];
                    B0_LINE_LO: nxt_q.y[3:0] = wv;
                    B0_LINE_HI: nxt_q.y[6:4] = wv[2:0];
                    B0_ADDR_CTL: begin
                        nxt_q.xinc = wv[CTL_XINC];
                        nxt_q.yinc = wv[CTL_YINC];
                        nxt_q.rev_seg = wv[CTL_REF];
                    end
                    B0_START_LO: nxt_q.start[3:0] = wv;
                    B0_START_HI: nxt_q.start[6:4] = wv[2:0];
                    B0_MODE: begin
                        nxt_q.inv = wv[MODE_INV];
                        nxt_q.mono = wv[MODE_MONO];
                        nxt_q.pwm = wv[MODE_PWM];
                    end
                    default: ;
                endcase
            end
        end else if (wr_fire) begin
            mem_we = 1'b1;
            mem_col = eff_col;
            mem_byte = wr_data;
            ram_acc = 1'b1;
        end

        // data shown during a ram read is the buffer from the previous ram read
        if (rd_start) begin
            nxt_q.rd_rs = s[SI_RS];
            nxt_q.doe = 1'b1;
            nxt_q.dout = s[SI_RS] ? {reg_val(q_ff, q_ff.rptr), q_ff.rptr}
                                  : q_ff.rbuf;
        end
        if (rd_end) begin
            nxt_q.doe = 1'b0;
            if (!q_ff.rd_rs) begin
                nxt_q.rbuf = ram[q_ff.y][{eff_col, 3'h0} +: DATA_W];
                ram_acc = 1'b1;
            end
        end
        if (!par) begin
            nxt_q.doe = 1'b0;
        end

        // column wraps into the next line when both increments are on
        if (ram_acc) begin
            if (q_ff.xinc) begin
                nxt_q.x = (q_ff.x == COL_MAX) ? '0 : 5'(q_ff.x + 5'h1);
            end
            if (q_ff.yinc && (!q_ff.xinc || q_ff.x == COL_MAX)) begin
                nxt_q.y = (q_ff.y == LINE_MAX) ? '0 : 7'(q_ff.y + 7'h1);
            end
        end

        // display readout runs from its own line counter
        nxt_q.lp_q = s[SI_LP];
        nxt_q.fm_q = s[SI_FM];
        lp_rise = s[SI_LP] & ~q_ff.lp_q;
        lp_fall = ~s[SI_LP] & q_ff.lp_q;
        fm_rise = s[SI_FM] & ~q_ff.fm_q;
        steps = q_ff.pwm ? GRAY_FIX_STEPS : GRAY_VAR_STEPS;
        base = fm_rise ? q_ff.start : q_ff.line_cnt;
        if (fm_rise) begin
            nxt_q.line_cnt = q_ff.start;
            nxt_q.phase = (q_ff.phase >= 4'(steps - 4'h1)) ? '0 : 4'(q_ff.phase + 4'h1);
        end
        if (lp_rise) begin
            nxt_q.latch = ram[base];
            nxt_q.line_cnt = (base == LINE_MAX) ? '0 : 7'(base + 7'h1);
        end
        if (lp_fall) begin
            for (int i = 0; i < ROW_BITS; i++) begin
                nxt_q.seg[i] = q_ff.latch[i] ^ q_ff.inv;
            end
            if (!q_ff.mono) begin
                nxt_q.seg = '0;
                for (int i = 0; i < PIX; i++) begin
                    code = q_ff.latch[CODE_W*i +: CODE_W];
                    level = q_ff.pwm ? {2'b00, code} : q_ff.pal[code];
                    // a level of n lights n of every period frames
                    nxt_q.seg[i] = (level > q_ff.phase);
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_ff <= ST_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // no reset on the array: contents are undefined until written
    always_ff @(posedge ref_clk_i) begin
        if (mem_we) begin
            ram[mem_row][{mem_col, 3'h0} +: DATA_W] <= mem_byte;
        end
    end

    assign host_data_bus_o = q_ff.dout;
    assign host_data_bus_oe_o = q_ff.doe;
    assign seg_on_o = q_ff.seg;

    AST_SER_NO_DRIVE: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !q_ff.stab[SI_PS] |=> !host_data_bus_oe_o)
        else $error("data bus driven in serial mode");

    AST_DUMMY_READ: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (rd_start && !q_ff.stab[SI_RS]) |=> host_data_bus_o == $past(q_ff.rbuf))
        else $error("ram read did not return the prior buffer");

    AST_REG_READ_ADDR: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (rd_start && q_ff.stab[SI_RS]) |=> host_data_bus_o[3:0] == $past(q_ff.rptr))
        else $error("register read low nibble is not the pointer");

    AST_BANK_ANY: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (wr_fire && wr_rs && wr_data[7:4] == BANK_REG_ADDR) |=> q_ff.bank == $past(wr_data[3:0]))
        else $error("bank register not written");

    AST_COL_INC: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (mem_we && q_ff.xinc && q_ff.x != COL_MAX) |=> q_ff.x == 5'($past(q_ff.x) + 5'h1))
        else $error("column did not advance after ram write");

    AST_REV_COL: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (mem_we && q_ff.rev_seg) |-> mem_col == 5'(COL_MAX - q_ff.x))
        else $error("reversed column mapping wrong");

    AST_LINE_PRESET: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (fm_rise && !lp_rise) |=> q_ff.line_cnt == $past(q_ff.start))
        else $error("line counter not preset on frame marker");

    AST_PAL_HOLD: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !(wr_fire && wr_rs && q_ff.bank == PAL_BANK) |=> $stable(q_ff.pal))
        else $error("palette changed without a palette write");

    AST_MONO_POL: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (lp_fall && q_ff.mono) |=> seg_on_o[0] == ($past(q_ff.latch[0]) ^ $past(q_ff.inv)))
        else $error("mono polarity wrong");

    AST_SER_BYTE: assert property (
        @(posedge serial_clk_i) disable iff (!rst_b_i)
        sh_ff.cnt == SER_LAST |=> hold_ff.tog != $past(hold_ff.tog))
        else $error("serial byte not formed at eighth clock");
endmodule : lhp_top

/* File: dv/lhp_host_model.sv */
// host microprocessor model driving the lcd host port pins
// assumes ref_clk_i is the device clock; serial clock made here, 48 ns period
module lhp_host_model (
    input wire logic ref_clk_i,
    input wire logic [lhp_pkg::DATA_W-1:0] bus_rd_i,
    input wire logic bus_oe_i,
    output logic serial_clk_o,
    output logic serial_data_o,
    output logic par_ser_sel_o,
    output logic bus_style_pin_o,
    output logic chip_sel_n_o,
    output logic ram_or_reg_sel_o,
    output logic read_strobe_n_o,
    output logic write_strobe_n_o,
    output logic [lhp_pkg::DATA_W-1:0] host_data_bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import lhp_pkg::*;

    initial begin
        serial_clk_o = 1'b0;
        serial_data_o = 1'b0;
        par_ser_sel_o = 1'b1;
        bus_style_pin_o = 1'b0;
        chip_sel_n_o = 1'b1;
        ram_or_reg_sel_o = 1'b0;
        read_strobe_n_o = 1'b1;
        write_strobe_n_o = 1'b1;
        host_data_bus_o = 8'h00;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : cyc

    // idle strobe levels differ: 68 style parks enable low
    task automatic set_mode(input logic par, input logic style);
        @(posedge ref_clk_i);
        par_ser_sel_o <= par;
        bus_style_pin_o <= style;
        read_strobe_n_o <= ~style;
        write_strobe_n_o <= 1'b1;
        cyc(4);
    endtask : set_mode

    task automatic pwr(input logic rs, input logic [7:0] d);
        @(posedge ref_clk_i);
        chip_sel_n_o <= 1'b0;
        ram_or_reg_sel_o <= rs;
        host_data_bus_o <= d;
        write_strobe_n_o <= 1'b0;
        if (bus_style_pin_o) begin
            read_strobe_n_o <= 1'b1;
        end
        cyc(4);
        if (bus_style_pin_o) begin
            read_strobe_n_o <= 1'b0;
        end else begin
            write_strobe_n_o <= 1'b1;
        end
        cyc(4);
        chip_sel_n_o <= 1'b1;
        write_strobe_n_o <= 1'b1;
        host_data_bus_o <= ~d; // released bus shows no stale value
        cyc(1);
    endtask : pwr

    task automatic prd(input logic rs, output logic [7:0] d, output logic oe);
        @(posedge ref_clk_i);
        chip_sel_n_o <= 1'b0;
        ram_or_reg_sel_o <= rs;
        read_strobe_n_o <= bus_style_pin_o;
        cyc(6);
        d = bus_rd_i;
        oe = bus_oe_i;
        read_strobe_n_o <= ~bus_style_pin_o;
        cyc(5);
        chip_sel_n_o <= 1'b1;
        cyc(1);
    endtask : prd

    // nbits below 8 models an aborted partial byte
    task automatic ser(input logic rs, input logic [7:0] d, input int nbits);
        @(posedge ref_clk_i);
        chip_sel_n_o <= 1'b0;
        ram_or_reg_sel_o <= rs;
        #30;
        for (int i = 0; i < nbits; i++) begin
            serial_data_o = d[7-i];
            #24 serial_clk_o = 1'b1;
            #24 serial_clk_o = 1'b0;
        end
        serial_data_o = ~serial_data_o;
        @(posedge ref_clk_i);
        chip_sel_n_o <= 1'b1;
        cyc(6);
    endtask : ser
endmodule : lhp_host_model

/* File: dv/lhp_top_tb.sv */
// self-checking bench for the lcd host port, display ram and line readout
// assumes lhp_host_model drives every host pin
module lhp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lhp_pkg::*;

    logic ref_clk, rst_b, line_pulse, frame_marker;
    logic sclk, sdata, ps, style, cs_n, rs, rd_n, wr_n;
    logic [DATA_W-1:0] din, dout;
    logic oe;
    logic [ROW_BITS-1:0] seg_on;
    int n_errors = 0;
    int comparisons = 0;

    lhp_top u_lhp_top (
        .ref_clk_i(ref_clk), .rst_b_i(rst_b), .serial_clk_i(sclk), .serial_data_i(sdata),
        .par_ser_sel_i(ps), .bus_style_pin_i(style), .chip_sel_n_i(cs_n),
        .ram_or_reg_sel_i(rs), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n),
        .host_data_bus_i(din), .line_pulse_i(line_pulse), .frame_marker_i(frame_marker),
        .host_data_bus_o(dout), .host_data_bus_oe_o(oe), .seg_on_o(seg_on)
    );

    lhp_host_model u_lhp_host_model (
        .ref_clk_i(ref_clk), .bus_rd_i(dout), .bus_oe_i(oe), .serial_clk_o(sclk),
        .serial_data_o(sdata), .par_ser_sel_o(ps), .bus_style_pin_o(style),
        .chip_sel_n_o(cs_n), .ram_or_reg_sel_o(rs), .read_strobe_n_o(rd_n),
        .write_strobe_n_o(wr_n), .host_data_bus_o(din)
    );

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk

    task automatic conclude();
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    task automatic rdreg(input logic [3:0] bank, input logic [3:0] a, output logic [7:0] d);
        logic o;
        u_lhp_host_model.pwr(1'b1, {BANK_REG_ADDR, RA_BANK});
        u_lhp_host_model.pwr(1'b1, {RA_ADDR, a});
        u_lhp_host_model.pwr(1'b1, {BANK_REG_ADDR, bank});
        u_lhp_host_model.prd(1'b1, d, o);
        chk(8'h01, {7'h0, o});
    endtask : rdreg

    task automatic pulse(input logic fm);
        @(posedge ref_clk);
        if (fm) frame_marker <= 1'b1;
        else line_pulse <= 1'b1;
        repeat (5) @(posedge ref_clk);
        frame_marker <= 1'b0;
        line_pulse <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask : pulse

    // reset palettes read back through the bank 2 pointer, both bus styles
    task automatic t_palette();
        logic [3:0] pal [4] = '{4'h0, 4'h5, 4'hA, 4'hF};
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            u_lhp_host_model.set_mode(1'b1, i[0]);
            rdreg(PAL_BANK, i[3:0], d);
            chk({pal[i], i[3:0]}, d);
        end
        u_lhp_host_model.pwr(1'b1, 8'h27);
        rdreg(PAL_BANK, 4'h2, d);
        chk(8'h72, d);
        $display("t_palette done");
    endtask : t_palette

    task automatic rdram(input logic [7:0] exp);
        logic [7:0] d;
        logic o;
        u_lhp_host_model.prd(1'b0, d, o);
        chk(exp, d);
    endtask : rdram

    task automatic t_ram();
        logic [7:0] d;
        logic o;
        u_lhp_host_model.set_mode(1'b1, 1'b0);
        u_lhp_host_model.pwr(1'b1, 8'hF0);
        u_lhp_host_model.pwr(1'b1, 8'h03);
        u_lhp_host_model.pwr(1'b1, 8'h10);
        u_lhp_host_model.pwr(1'b1, 8'h22);
        u_lhp_host_model.pwr(1'b1, 8'h30);
        u_lhp_host_model.pwr(1'b1, 8'h41);
        u_lhp_host_model.pwr(1'b0, 8'hA5);
        u_lhp_host_model.pwr(1'b0, 8'h3C);
        u_lhp_host_model.pwr(1'b1, 8'h03);
        u_lhp_host_model.prd(1'b0, d, o);
        rdram(8'hA5);
        rdram(8'h3C);
        // reversed columns: register 0,1 land on 19H,18H
        u_lhp_host_model.pwr(1'b1, 8'h45);
        u_lhp_host_model.pwr(1'b1, 8'h00);
        u_lhp_host_model.pwr(1'b0, 8'h81);
        u_lhp_host_model.pwr(1'b0, 8'h42);
        u_lhp_host_model.pwr(1'b1, 8'h41);
        u_lhp_host_model.pwr(1'b1, 8'h08);
        u_lhp_host_model.pwr(1'b1, 8'h11);
        u_lhp_host_model.prd(1'b0, d, o);
        rdram(8'h42);
        rdram(8'h81);
        $display("t_ram done");
    endtask : t_ram

    task automatic t_serial();
        logic [7:0] cmd [6] = '{8'hF0, 8'h05, 8'h10, 8'h21, 8'h30, 8'h40};
        logic [7:0] d;
        logic o;
        u_lhp_host_model.set_mode(1'b0, 1'b0);
        foreach (cmd[i]) u_lhp_host_model.ser(1'b1, cmd[i], 8);
        u_lhp_host_model.ser(1'b0, 8'h00, 3);
        u_lhp_host_model.ser(1'b0, 8'h5A, 8);
        u_lhp_host_model.prd(1'b0, d, o);
        chk(8'h00, {7'h0, o});
        u_lhp_host_model.set_mode(1'b1, 1'b0);
        u_lhp_host_model.prd(1'b0, d, o);
        rdram(8'h5A);
        $display("t_serial done");
    endtask : t_serial

    task automatic t_disp();
        u_lhp_host_model.pwr(1'b1, 8'h51);
        u_lhp_host_model.pwr(1'b1, 8'h60);
        u_lhp_host_model.pwr(1'b1, 8'h72);
        pulse(1'b1);
        pulse(1'b0);
        chk(8'h5A, seg_on[47:40]);
        u_lhp_host_model.pwr(1'b1, 8'h73);
        pulse(1'b1);
        pulse(1'b0);
        chk(8'hA5, seg_on[47:40]);
        pulse(1'b0);
        chk(8'h5A, seg_on[31:24]);
        // fixed gray, pixels 20..23 hold codes 2,2,1,1; third frame wraps the 3-step phase
        u_lhp_host_model.pwr(1'b1, 8'h74);
        pulse(1'b1);
        pulse(1'b0);
        chk(8'h0F, {4'h0, seg_on[23:20]});
        pulse(1'b1);
        pulse(1'b0);
        chk(8'h03, {4'h0, seg_on[23:20]});
        $display("t_disp done");
    endtask : t_disp

    initial begin
        rst_b = 1'b0;
        line_pulse = 1'b0;
        frame_marker = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_palette();
        t_ram();
        t_serial();
        t_disp();
        conclude();
    end

    // full run is about 900 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        conclude();
    end
endmodule : lhp_top_tb
